// *** tsp_desc_cache.sv ***
// Four-entry fully associative interface descriptor cache
`default_nettype none

module tsp_desc_cache (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Lookup
  input  wire logic [7:0]  lk_ptr,
  output logic             hit,
  output logic [31:0]      hit_data,
  // Fill from second level
  input  wire logic        fill_valid,
  input  wire logic [7:0]  fill_ptr,
  input  wire logic [31:0] fill_data
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  tsp_pkg::tsp_cache_st_t r;     // Registered state
  tsp_pkg::tsp_cache_st_t s;     // Next state
  logic [tsp_pkg::N_DESC-1:0] match;  // Per entry tag match

  // Per entry compare
  genvar gi;
  generate
    for (gi = 0; gi < tsp_pkg::N_DESC; gi++)
    begin : g_match
      assign match[gi] = r.valid[gi] && (r.tag[gi] == lk_ptr);
    end
  endgenerate

  // Hit select, entries are unique so an OR mux suffices
  always_comb
  begin
    hit      = |match;
    hit_data = '0;
    for (int i = 0; i < tsp_pkg::N_DESC; i++)
    begin
      if (match[i])
        hit_data = hit_data | r.data[i];
    end
  end

  // Round robin replacement on fill
  always_comb
  begin
    s = r;
    if (fill_valid)
    begin
      s.valid[r.victim] = 1'b1;
      s.tag[r.victim]   = fill_ptr;
      s.data[r.victim]  = fill_data;
      s.victim          = r.victim + 2'h1;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= s;
  end

endmodule : tsp_desc_cache

`default_nettype wire

// *** tsp_far_end.sv ***
// Far side model: second level descriptor cache and thread dispatcher
`default_nettype none

module tsp_far_end (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Response speed select
  input  wire logic        slow,
  // Second level cache
  input  wire logic        l2_req,
  input  wire logic [7:0]  l2_ptr,
  output logic             l2_valid,
  output logic [31:0]      l2_data,
  // Dispatcher
  input  wire logic        disp_valid,
  output logic             disp_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       l2_wait_r;  // Fetch outstanding
  logic [3:0] l2_cnt_r;   // Fetch delay count
  logic [3:0] disp_cnt_r; // Dispatch delay count

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor fetch, answered in request order, one at a time
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      l2_wait_r <= 1'b0;
      l2_cnt_r  <= 4'h0;
      l2_valid  <= 1'b0;
      l2_data   <= 32'h0;
    end
    else if (l2_req)
    begin
      l2_wait_r <= 1'b1;
      l2_cnt_r  <= slow ? 4'h6 : 4'h0;
      l2_valid  <= 1'b0;
      l2_data   <= ~l2_data;
    end
    else if (l2_wait_r && l2_cnt_r == 4'h0)
    begin
      l2_wait_r <= 1'b0;
      l2_valid  <= 1'b1;
      l2_data   <= {l2_ptr, ~l2_ptr, l2_ptr, 8'hA5};
    end
    else
    begin
      // Idle data toggles, never holds the last value
      l2_valid <= 1'b0;
      l2_data  <= ~l2_data;
      l2_cnt_r <= l2_cnt_r - {3'h0, |l2_cnt_r};
    end

  ////////////////////////////////////////////////////////////////////////////
  // Dispatcher acknowledge, one pulse per request
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      disp_ack   <= 1'b0;
      disp_cnt_r <= 4'h0;
    end
    else if (disp_valid && !disp_ack && disp_cnt_r == (slow ? 4'h5 : 4'h1))
    begin
      disp_ack   <= 1'b1;
      disp_cnt_r <= 4'h0;
    end
    else
    begin
      disp_ack   <= 1'b0;
      disp_cnt_r <= (disp_valid && !disp_ack) ? disp_cnt_r + 4'h1 : 4'h0;
    end
endmodule : tsp_far_end

`default_nettype wire

// *** tsp_pkg.sv ***
// Shared constants, types and state records of the root thread spawner
`default_nettype none

package tsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int CQ_DEPTH = 8;        // Child request queue entries
  localparam int N_SLOTS  = 8;        // Root tracking slots
  localparam int N_DESC   = 4;        // First-level descriptor cache entries

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL     = 4'h0;  // Max roots, scratch size, tracking
  localparam logic [3:0] REG_SCR_BASE = 4'h4;  // Scratch region base
  localparam logic [3:0] REG_STATUS   = 4'h8;  // Live counters, read only

  // Control fields
  localparam int CTRL_MAXR_LSB = 0;   // 4 bits, maximum outstanding roots
  localparam int CTRL_SCR_LSB  = 8;   // 8 bits, scratch size per root
  localparam int CTRL_DEP_BIT  = 16;  // Dependency tracking enable

  // Status fields
  localparam int ST_OUT_LSB  = 0;     // 4 bits, outstanding roots
  localparam int ST_CQ_LSB   = 8;     // 4 bits, child queue fill
  localparam int ST_SLOT_LSB = 16;    // 8 bits, busy root slots
  localparam int ST_BUSY_BIT = 24;    // Thread in flight

  // Reset values
  localparam logic [3:0]  MAXR_RST = 4'h8;
  localparam logic [7:0]  SCR_RST  = 8'h00;
  localparam logic [15:0] SCRB_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [1:0] {TSP_IDLE, TSP_LOOKUP, TSP_FETCH, TSP_DISPATCH} tsp_fsm_t;
  typedef enum logic [1:0] {TSP_MSG_CHILD, TSP_MSG_SPAWN_ROOT, TSP_MSG_TERM,
                            TSP_MSG_REL} tsp_msg_kind_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [7:0] desc_ptr;   // Interface descriptor pointer
    logic [7:0] handle;     // Return buffer handle from the front end
    logic       children;   // Children present flag
    logic       sync;       // Synchronized root
    logic       ext;        // From the extended work item command
    logic       scratch;    // Wants scratch memory
  } tsp_root_t;

  typedef struct packed {
    tsp_msg_kind_t kind;    // Message kind
    logic [7:0]    desc_ptr; // Child descriptor pointer
    logic [7:0]    pay_ptr; // Child payload pointer
    logic [2:0]    slot;    // Root slot for terminate and release
  } tsp_msg_t;

  typedef struct packed {
    logic [7:0]  desc_ptr;  // Descriptor pointer looked up
    logic [31:0] desc;      // Descriptor contents
    logic        is_root;   // Root thread
    logic        fr_hdr_valid; // First-register header present
    logic        children;  // Handle forwarded as return handle
    logic [2:0]  slot;      // Root slot
    logic        use_scr;   // Scratch pointer valid
    logic [15:0] scr_ptr;   // Scratch pointer
    logic [7:0]  handle;    // Return buffer handle
    logic [7:0]  pay_ptr;   // Child payload pointer
  } tsp_hdr_t;

  // Descriptor cache state
  typedef struct packed {
    logic [N_DESC-1:0]             valid;
    logic [N_DESC-1:0][7:0]        tag;
    logic [N_DESC-1:0][31:0]       data;
    logic [1:0]                    victim;
  } tsp_cache_st_t;

endpackage : tsp_pkg

`default_nettype wire

// *** tsp_spawner.sv ***
// Root and child thread spawner: arbitration, descriptor fetch, dispatch, root tracking
//
// Design decisions made here: the plain strobed port and the register addresses.
`default_nettype none

module tsp_spawner (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // Register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // Root requests from the video front end
  input  wire logic               root_valid,
  input  wire tsp_pkg::tsp_root_t root_req,
  output logic                    root_ready,
  // Thread messages
  input  wire logic               msg_valid,
  input  wire tsp_pkg::tsp_msg_t  msg,
  output logic                    cq_pop,
  // Dependency tracking
  input  wire logic               dep_ready,
  // Second level descriptor cache
  output logic                    l2_req,
  output logic [7:0]              l2_ptr,
  input  wire logic               l2_valid,
  input  wire logic [31:0]        l2_data,
  // Thread dispatcher
  output logic                    disp_valid,
  output tsp_pkg::tsp_hdr_t       disp_hdr,
  input  wire logic               disp_ack,
  // Handle release to the front end
  output logic                    rel_valid,
  output logic [7:0]              rel_handle
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    tsp_pkg::tsp_fsm_t                         fsm;       // Thread pipeline state
    tsp_pkg::tsp_msg_t [tsp_pkg::CQ_DEPTH-1:0] cq;        // Child queue storage
    logic [2:0]                                cq_rd;     // Queue read index
    logic [2:0]                                cq_wr;     // Queue write index
    logic [3:0]                                cq_cnt;    // Queue fill
    tsp_pkg::tsp_hdr_t                         hdr;       // Header under build
    logic                                      disp_valid; // Dispatch request
    logic [tsp_pkg::N_SLOTS-1:0]               sl_valid;  // Busy root slots
    logic [tsp_pkg::N_SLOTS-1:0]               sl_held;   // Handle still held
    logic [tsp_pkg::N_SLOTS-1:0][7:0]          sl_handle; // Held handle per slot
    logic [3:0]                                outst;     // Outstanding roots
    logic [3:0]                                max_roots; // Root maximum
    logic [7:0]                                scr_size;  // Scratch size per root
    logic [15:0]                               scr_base;  // Scratch region base
    logic                                      dep_en;    // Dependency tracking on
    logic [31:0]                               rdata;     // Read data
    logic                                      l2_req;    // Miss request pulse
    logic                                      rel_valid; // Release pulse
    logic [7:0]                                rel_handle; // Released handle
  } tsp_st_t;

  tsp_st_t r;                     // Registered state
  tsp_st_t s;                     // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Lowest free root slot
  function automatic logic [3:0] free_slot_f(input logic [tsp_pkg::N_SLOTS-1:0] busy);
    logic [3:0] res;
    res = 4'h8;
    for (int i = tsp_pkg::N_SLOTS - 1; i >= 0; i--)
    begin
      if (!busy[i])
        res = 4'(i);
    end
    return res;
  endfunction : free_slot_f

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration
  tsp_pkg::tsp_msg_t head;        // Child queue head
  logic              cq_ne;       // Child queue not empty
  logic              head_sr;     // Spawn-root message at head
  logic              idle;        // Pipeline free
  logic [3:0]        free_slot;   // Free slot, 8 when none
  logic              cap_ok;      // Root may enter arbitration
  logic              dep_ok;      // Dependency gate open
  logic              sync_go;     // Synchronized pair taken
  logic              child_go;    // Child head taken
  logic              nroot_go;    // Plain root taken
  logic              push;        // Message stored
  logic              hit;         // Descriptor cache hit
  logic [31:0]       hit_data;    // Cached descriptor

  assign head      = r.cq[r.cq_rd];
  assign cq_ne     = r.cq_cnt != 4'h0;
  // Any sender may issue a spawn-root; no sender field is checked
  assign head_sr   = cq_ne && (head.kind == tsp_pkg::TSP_MSG_SPAWN_ROOT);
  assign idle      = r.fsm == tsp_pkg::TSP_IDLE;
  assign free_slot = free_slot_f(r.sl_valid);
  // Only the root count is capped, children never are
  assign cap_ok    = (r.outst < r.max_roots) && !free_slot[3];
  assign dep_ok    = !(root_req.ext && r.dep_en) || dep_ready;
  // Pairing of synchronized root with spawn-root message
  assign sync_go   = idle && root_valid && root_req.sync && head_sr && cap_ok
                     && dep_ok;
  // Children first unless the head waits for a synchronized root
  assign child_go  = idle && cq_ne && !head_sr;
  assign nroot_go  = idle && root_valid && !root_req.sync && cap_ok && !child_go;
  assign root_ready = sync_go || nroot_go;
  assign cq_pop     = sync_go || child_go;
  assign push       = msg_valid && ((r.cq_cnt < 4'(tsp_pkg::CQ_DEPTH)) || cq_pop);

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor cache
  tsp_desc_cache u_cache (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .lk_ptr     (r.hdr.desc_ptr),
    .hit        (hit),
    .hit_data   (hit_data),
    .fill_valid (r.fsm == tsp_pkg::TSP_FETCH && l2_valid),
    .fill_ptr   (r.hdr.desc_ptr),
    .fill_data  (l2_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s           = r;
    s.rdata     = '0;
    s.l2_req    = 1'b0;
    s.rel_valid = 1'b0;

    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == tsp_pkg::REG_CTRL)
      begin
        s.max_roots = reg_wdata[tsp_pkg::CTRL_MAXR_LSB +: 4];
        s.scr_size  = reg_wdata[tsp_pkg::CTRL_SCR_LSB +: 8];
        s.dep_en    = reg_wdata[tsp_pkg::CTRL_DEP_BIT];
      end
      else if (reg_addr == tsp_pkg::REG_SCR_BASE)
        s.scr_base = reg_wdata[15:0];
    end

    // Register reads, unmapped reads zero
    if (reg_rd)
    begin
      if (reg_addr == tsp_pkg::REG_CTRL)
      begin
        s.rdata[tsp_pkg::CTRL_MAXR_LSB +: 4] = r.max_roots;
        s.rdata[tsp_pkg::CTRL_SCR_LSB +: 8]  = r.scr_size;
        s.rdata[tsp_pkg::CTRL_DEP_BIT]       = r.dep_en;
      end
      else if (reg_addr == tsp_pkg::REG_SCR_BASE)
        s.rdata[15:0] = r.scr_base;
      else if (reg_addr == tsp_pkg::REG_STATUS)
      begin
        s.rdata[tsp_pkg::ST_OUT_LSB +: 4]  = r.outst;
        s.rdata[tsp_pkg::ST_CQ_LSB +: 4]   = r.cq_cnt;
        s.rdata[tsp_pkg::ST_SLOT_LSB +: 8] = r.sl_valid;
        s.rdata[tsp_pkg::ST_BUSY_BIT]      = !idle;
      end
    end

    // Child queue, push and pop may share a cycle
    if (push)
    begin
      s.cq[r.cq_wr] = msg;
      s.cq_wr       = r.cq_wr + 3'h1;
    end
    if (cq_pop)
      s.cq_rd = r.cq_rd + 3'h1;
    s.cq_cnt = r.cq_cnt + {3'h0, push} - {3'h0, cq_pop};

    // Thread pipeline
    case (r.fsm)
      tsp_pkg::TSP_IDLE:
      begin
        if (root_ready)
        begin
          // Root: reserve a slot and build both headers
          s.hdr          = '0;
          s.hdr.desc_ptr = root_req.desc_ptr;
          s.hdr.is_root  = 1'b1;
          s.hdr.fr_hdr_valid = 1'b1;
          s.hdr.children = root_req.children;
          s.hdr.slot     = free_slot[2:0];
          s.hdr.handle   = root_req.handle;
          s.hdr.use_scr  = root_req.scratch;
          // Same scratch size for every root
          if (root_req.scratch)
            s.hdr.scr_ptr = 16'(r.scr_base + 16'(free_slot[2:0]) * 16'(r.scr_size));
          s.sl_valid[free_slot[2:0]] = 1'b1;
          s.fsm                      = tsp_pkg::TSP_LOOKUP;
        end
        else if (child_go)
        begin
          case (head.kind)
            tsp_pkg::TSP_MSG_CHILD:
            begin
              // Child: transparent header only, no bookkeeping
              s.hdr          = '0;
              s.hdr.desc_ptr = head.desc_ptr;
              s.hdr.pay_ptr  = head.pay_ptr;
              s.fsm          = tsp_pkg::TSP_LOOKUP;
            end
            tsp_pkg::TSP_MSG_TERM:
            begin
              // Root retired: free slot and scratch, drop any held handle
              if (r.sl_valid[head.slot])
              begin
                s.sl_valid[head.slot] = 1'b0;
                s.sl_held[head.slot]  = 1'b0;
                s.rel_valid           = r.sl_held[head.slot];
                s.rel_handle          = r.sl_handle[head.slot];
                if (r.outst != 4'h0)
                  s.outst = r.outst - 4'h1;
              end
            end
            tsp_pkg::TSP_MSG_REL:
            begin
              // Early release from a running root
              if (r.sl_valid[head.slot] && r.sl_held[head.slot])
              begin
                s.sl_held[head.slot] = 1'b0;
                s.rel_valid          = 1'b1;
                s.rel_handle         = r.sl_handle[head.slot];
              end
            end
            default:
            begin
              s.fsm = tsp_pkg::TSP_IDLE;
            end
          endcase
        end
      end
      tsp_pkg::TSP_LOOKUP:
      begin
        // One lookup in flight keeps descriptors in request order
        if (hit)
        begin
          s.hdr.desc  = hit_data;
          s.disp_valid = 1'b1;
          s.fsm       = tsp_pkg::TSP_DISPATCH;
        end
        else
        begin
          s.l2_req = 1'b1;
          s.fsm    = tsp_pkg::TSP_FETCH;
        end
      end
      tsp_pkg::TSP_FETCH:
      begin
        if (l2_valid)
        begin
          s.hdr.desc   = l2_data;
          s.disp_valid = 1'b1;
          s.fsm      = tsp_pkg::TSP_DISPATCH;
        end
      end
      tsp_pkg::TSP_DISPATCH:
      begin
        if (disp_ack)
        begin
          s.disp_valid = 1'b0;
          s.fsm      = tsp_pkg::TSP_IDLE;
          if (r.hdr.is_root)
          begin
            s.outst = r.outst + 4'h1;
            s.sl_handle[r.hdr.slot] = r.hdr.handle;
            // Handle kept only when the root will have children
            s.sl_held[r.hdr.slot]   = r.hdr.children;
            if (!r.hdr.children)
            begin
              s.rel_valid  = 1'b1;
              s.rel_handle = r.hdr.handle;
            end
          end
        end
      end
      default:
      begin
        s.fsm = tsp_pkg::TSP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r           <= '0;
      r.max_roots <= tsp_pkg::MAXR_RST;
      r.scr_size  <= tsp_pkg::SCR_RST;
      r.scr_base  <= tsp_pkg::SCRB_RST;
    end
    else
      r <= s;
  end

  // Outputs from flops
  assign reg_rdata  = r.rdata;
  assign l2_req     = r.l2_req;
  assign l2_ptr     = r.hdr.desc_ptr;
  assign disp_valid = r.disp_valid;
  assign disp_hdr   = r.hdr;
  assign rel_valid  = r.rel_valid;
  assign rel_handle = r.rel_handle;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_root_cap;
    @(posedge mclk) disable iff (sys_rst)
      disp_valid && disp_hdr.is_root |-> r.outst < r.max_roots;
  endproperty
  a_root_cap: assert property (p_root_cap) else $error("root over maximum");

  property p_child_prio;
    @(posedge mclk) disable iff (sys_rst)
      idle && cq_ne && head.kind == tsp_pkg::TSP_MSG_CHILD
      |=> r.fsm == tsp_pkg::TSP_LOOKUP && !r.hdr.is_root;
  endproperty
  a_child_prio: assert property (p_child_prio) else $error("child not first");

  property p_sync_wait;
    @(posedge mclk) disable iff (sys_rst)
      root_valid && root_req.sync && !head_sr |-> !root_ready;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync root went alone");

  property p_sr_block;
    @(posedge mclk) disable iff (sys_rst)
      head_sr && !(root_valid && root_req.sync) |-> !cq_pop;
  endproperty
  a_sr_block: assert property (p_sr_block) else $error("spawn-root not blocking");

  property p_pair;
    @(posedge mclk) disable iff (sys_rst)
      root_ready && root_req.sync |-> cq_pop && head_sr;
  endproperty
  a_pair: assert property (p_pair) else $error("pair not removed together");

  property p_rel_nochild;
    @(posedge mclk) disable iff (sys_rst)
      disp_valid && disp_ack && disp_hdr.is_root && !disp_hdr.children
      |=> rel_valid && rel_handle == $past(disp_hdr.handle);
  endproperty
  a_rel_nochild: assert property (p_rel_nochild) else $error("no release at ack");

  property p_hold_child;
    @(posedge mclk) disable iff (sys_rst)
      disp_valid && disp_ack && disp_hdr.is_root && disp_hdr.children |=> !rel_valid;
  endproperty
  a_hold_child: assert property (p_hold_child) else $error("handle released early");

  property p_count_up;
    @(posedge mclk) disable iff (sys_rst)
      disp_valid && disp_ack && disp_hdr.is_root |=> r.outst == $past(r.outst) + 4'h1;
  endproperty
  a_count_up: assert property (p_count_up) else $error("count missed dispatch");

  property p_miss_wait;
    @(posedge mclk) disable iff (sys_rst)
      l2_req |-> !disp_valid ##1 (!disp_valid [*1]);
  endproperty
  a_miss_wait: assert property (p_miss_wait) else $error("dispatch before fill");

  property p_first_hdr;
    @(posedge mclk) disable iff (sys_rst)
      disp_valid |-> disp_hdr.fr_hdr_valid == disp_hdr.is_root;
  endproperty
  a_first_hdr: assert property (p_first_hdr) else $error("header kind wrong");

endmodule : tsp_spawner

`default_nettype wire

// *** tsp_spawner_tb_top.sv ***
// Self-checking testbench of the root thread spawner
`default_nettype none

module tsp_spawner_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, root_valid = 0, msg_valid = 0;
  logic slow = 0, dep_ready = 1, root_ready, cq_pop, l2_req, l2_valid, disp_valid, disp_ack;
  logic rel_valid;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, l2_data;
  logic [7:0]  l2_ptr, rel_handle, last_rel;
  tsp_pkg::tsp_root_t root_req = '0;
  tsp_pkg::tsp_msg_t  msg = '0;
  tsp_pkg::tsp_hdr_t  disp_hdr, hdr;
  int mismatches = 0, n_tests = 0, n_rel = 0, n_l2 = 0;
  logic [31:0] rv;
  logic pop_at_take;

  tsp_spawner uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .root_valid(root_valid),
    .root_req(root_req), .root_ready(root_ready), .msg_valid(msg_valid), .msg(msg),
    .cq_pop(cq_pop), .dep_ready(dep_ready), .l2_req(l2_req), .l2_ptr(l2_ptr),
    .l2_valid(l2_valid), .l2_data(l2_data), .disp_valid(disp_valid), .disp_hdr(disp_hdr),
    .disp_ack(disp_ack), .rel_valid(rel_valid), .rel_handle(rel_handle));
  tsp_far_end far (.mclk(mclk), .sys_rst(sys_rst), .slow(slow), .l2_req(l2_req),
    .l2_ptr(l2_ptr), .l2_valid(l2_valid), .l2_data(l2_data), .disp_valid(disp_valid),
    .disp_ack(disp_ack));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and output monitors
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (rel_valid === 1'b1)
    begin
      n_rel++;
      last_rel = rel_handle;
    end
    if (l2_req === 1'b1)
      n_l2++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 1'b0;
    @(negedge mclk) d = reg_rdata;
  endtask : rd
  task automatic msend(input tsp_pkg::tsp_msg_kind_t k, input logic [2:0] s);
    @(posedge mclk) {msg_valid, msg} <= {1'b1, k, 8'h30, 8'h44, s};
    @(posedge mclk) msg_valid <= 1'b0;
  endtask : msend
  // Present a root until taken; report child queue pop at the taking edge
  task automatic root(input logic [7:0] p, h, input logic ch, sy, sc);
    @(posedge mclk) {root_valid, root_req} <= {1'b1, p, h, ch, sy, 1'b0, sc};
    repeat (200)
    begin
      @(posedge mclk);
      if (root_ready === 1'b1)
        break;
    end
    chk(root_ready, 1'b1);
    pop_at_take = cq_pop;
    root_valid <= 1'b0;
  endtask : root
  task automatic get_td();
    int i;
    for (i = 0; i < 100 && disp_valid !== 1'b1; i++)
      @(negedge mclk);
    hdr = disp_hdr;
    chk(disp_valid, 1'b1);
    chk(hdr.desc, {hdr.desc_ptr, ~hdr.desc_ptr, hdr.desc_ptr, 8'hA5});
    while (disp_ack !== 1'b1 && i++ < 200)
      @(negedge mclk);
    repeat (3) @(negedge mclk);
  endtask : get_td
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_release();
    root(8'h10, 8'hA1, 1'b0, 1'b0, 1'b1);
    get_td();
    chk(hdr.fr_hdr_valid, 1'b1);
    chk(last_rel, 8'hA1);
    chk(hdr.scr_ptr, 16'h0100 + 16'(hdr.slot) * 16'h0020);
    root(8'h10, 8'hA2, 1'b1, 1'b0, 1'b0);
    get_td();
    chk(hdr.handle, 8'hA2);
    chk(n_l2, 1);
    chk(n_rel, 1);
    msend(tsp_pkg::TSP_MSG_REL, hdr.slot);
    repeat (4) @(posedge mclk);
    chk(n_rel, 2);
    chk(last_rel, 8'hA2);
    rd(tsp_pkg::REG_STATUS, rv);
    chk(rv[3:0], 4'h2);
  endtask : t_release
  task automatic t_max();
    wr(tsp_pkg::REG_CTRL, 32'h0000_0002);
    // Two roots out already: the third is held off by the root maximum
    @(posedge mclk) {root_valid, root_req} <= {1'b1, 8'h20, 8'hB1, 4'b1000};
    repeat (10) @(negedge mclk) chk({root_ready, disp_valid}, 2'b00);
    // Slot 0 root spawned no children, so it may retire now
    fork
      msend(tsp_pkg::TSP_MSG_TERM, 3'h0);
      root(8'h20, 8'hB1, 1'b1, 1'b0, 1'b0);
    join
    get_td();
    chk(hdr.desc_ptr, 8'h20);
    chk(hdr.slot, 3'h0);
  endtask : t_max
  task automatic t_sync();
    wr(tsp_pkg::REG_CTRL, 32'h0001_0008);
    // Extended synchronized root, tracker not ready yet
    @(posedge mclk) {dep_ready, root_valid, root_req} <= {2'b01, 8'h11, 8'hC1, 4'b0110};
    repeat (6) @(negedge mclk) chk(root_ready, 1'b0);
    // One spawn-root for the one synchronized root keeps the pairing balanced
    msend(tsp_pkg::TSP_MSG_SPAWN_ROOT, 3'h0);
    repeat (4) @(negedge mclk) chk({root_ready, cq_pop}, 2'b00);
    fork
      @(posedge mclk) dep_ready <= 1'b1;
      root(8'h11, 8'hC1, 1'b0, 1'b1, 1'b0);
    join
    chk(pop_at_take, 1'b1);
    get_td();
    chk(hdr.is_root, 1'b1);
  endtask : t_sync
  task automatic t_prio();
    wr(tsp_pkg::REG_CTRL, 32'h0000_0008);
    msend(tsp_pkg::TSP_MSG_CHILD, 3'h0);
    // Root waits behind the child; first dispatch must be the child
    fork
      root(8'h12, 8'hD1, 1'b0, 1'b0, 1'b0);
      get_td();
    join
    chk({hdr.is_root, hdr.fr_hdr_valid}, 2'b00);
    chk(hdr.pay_ptr, 8'h44);
    get_td();
    chk({hdr.is_root, hdr.desc_ptr}, {1'b1, 8'h12});
  endtask : t_prio

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    wr(tsp_pkg::REG_CTRL, 32'h0000_2008);
    wr(tsp_pkg::REG_SCR_BASE, 32'h0000_0100);
    t_release();
    slow <= 1'b1;
    t_max();
    t_sync();
    t_prio();
    finish_test();
  end
  initial
  begin
    #400000;
    mismatches++;
    finish_test();
  end
endmodule : tsp_spawner_tb_top

`default_nettype wire
